// [rtl/tmr_bus_if.sv]
// Register bus joining the timer block and its bus master.
// Assumes both ends share clk; the testbench supplies it.
`timescale 1ns/1ps

interface tmr_bus_if (
	input wire logic clk
);
	logic psel; // Slave select
	logic penable; // Access phase
	logic pwrite; // Write when high
	logic [tmr_pkg::AW-1:0] paddr; // Byte address
	logic [tmr_pkg::DW-1:0] pwdata; // Write data
	logic [2:0] pprot; // Protection attributes
	logic [tmr_pkg::DW-1:0] prdata; // Read data
	logic pready; // Transfer done
	logic pslverr; // Guard refusal

	// Timer end
	modport device (
		input psel,
		input penable,
		input pwrite,
		input paddr,
		input pwdata,
		input pprot,
		output prdata,
		output pready,
		output pslverr
	);

	// Master end
	modport host (
		output psel,
		output penable,
		output pwrite,
		output paddr,
		output pwdata,
		output pprot,
		input prdata,
		input pready,
		input pslverr
	);
endinterface : tmr_bus_if

// [rtl/tmr_device.sv]
// Two-channel down-counting timer with toggle / PWM outputs.
// Assumes counting clock equals clk and a 16-bit register bus.
`timescale 1ns/1ps

module tmr_device (
	input wire logic clk,
	input wire logic srst,
	tmr_bus_if.device bus,
	output logic [tmr_pkg::NUM_TIMERS-1:0] timer_toggle,
	output logic [tmr_pkg::NUM_TIMERS-1:0] timer_irq
);

	////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [tmr_pkg::TW-1:0] load; // First reload value
		logic [tmr_pkg::TW-1:0] load2; // High-phase reload value
		logic [tmr_pkg::DW-1:0] sh_load; // Shadow low half
		logic [tmr_pkg::DW-1:0] sh_load2; // Shadow low half
		logic [tmr_pkg::DW-1:0] snap; // Upper half of live count
		logic [tmr_pkg::CTRL_W-1:0] ctrl; // Per-timer control
		logic [tmr_pkg::TW-1:0] count; // Live count
		logic tog; // Square-wave output
		logic raw; // Unmasked interrupt
		logic [tmr_pkg::GUARD_W-1:0] guard; // Access guard bits
		logic en_d; // Enable seen last cycle
	} timer_t;

	typedef struct packed {
		timer_t [tmr_pkg::NUM_TIMERS-1:0] tm;
		logic [tmr_pkg::DW-1:0] rdata; // Read data for access phase
		logic err; // Refusal for access phase
	} dev_state_t;

	dev_state_t st; // Registered state
	dev_state_t next_st; // Next state

	////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Base address of a timer's register block
	function automatic logic [tmr_pkg::AW-1:0] tbase(input int t);
		tbase = 8'(t) * tmr_pkg::TIMER_STRIDE;
	endfunction : tbase

	// Address of a per-timer register in the upper table
	function automatic logic [tmr_pkg::AW-1:0] tslot(
		input logic [tmr_pkg::AW-1:0] off, input int t);
		tslot = off + 8'(t) * tmr_pkg::REG_STRIDE;
	endfunction : tslot

	// Masked status of one timer
	function automatic logic masked(input timer_t tm);
		masked = tm.raw & ~tm.ctrl[tmr_pkg::CTRL_MASK];
	endfunction : masked

	// Full word held at a word-aligned address; unmapped reads zero
	function automatic logic [31:0] word_value(input dev_state_t s,
		input logic [tmr_pkg::AW-1:0] wa);
		logic [31:0] v;
		v = 32'h0;
		for (int t = 0; t < tmr_pkg::NUM_TIMERS; t++) begin
			if (wa == tbase(t) + tmr_pkg::OFF_LOAD) begin
				v = s.tm[t].load;
			end
			if (wa == tbase(t) + tmr_pkg::OFF_LIVE) begin
				v = s.tm[t].count;
			end
			if (wa == tbase(t) + tmr_pkg::OFF_CTRL) begin
				v = {27'h0, s.tm[t].ctrl};
			end
			if (wa == tbase(t) + tmr_pkg::OFF_ISTAT) begin
				v = {31'h0, masked(s.tm[t])};
			end
			if (tmr_pkg::EXT_MODE && wa == tslot(tmr_pkg::OFF_LOAD2, t)) begin
				v = s.tm[t].load2;
			end
			if (tmr_pkg::GUARD_PRESENT
				&& wa == tslot(tmr_pkg::OFF_GUARD, t)) begin
				v = {29'h0, s.tm[t].guard};
			end
			if (wa == tmr_pkg::OFF_ALL_ISTAT) begin
				v[t] = masked(s.tm[t]);
			end
			if (wa == tmr_pkg::OFF_RAW) begin
				v[t] = s.tm[t].raw;
			end
		end
		if (wa == tmr_pkg::OFF_REL) begin
			v = tmr_pkg::RELEASE_PARAM;
		end
		word_value = v;
	endfunction : word_value

	// True when the address falls on a guarded register of timer t
	function automatic logic guarded(input logic [tmr_pkg::AW-1:0] wa,
		input int t);
		guarded = (wa >= tbase(t) && wa < tbase(t) + tmr_pkg::TIMER_STRIDE)
			|| wa == tslot(tmr_pkg::OFF_LOAD2, t);
	endfunction : guarded

	// Access allowed under the current guard settings
	function automatic logic access_ok(input dev_state_t s,
		input logic [tmr_pkg::AW-1:0] wa, input logic [2:0] prot);
		logic ok;
		ok = 1'b1;
		for (int t = 0; t < tmr_pkg::NUM_TIMERS; t++) begin
			if (guarded(wa, t) && s.tm[t].guard != 3'h0
				&& prot != s.tm[t].guard) begin
				ok = 1'b0;
			end
		end
		access_ok = ok;
	endfunction : access_ok

	////////////////////////////////////////////////////////////////////
	// Bus decode
	logic [tmr_pkg::AW-1:0] wa; // Word-aligned address
	logic upper; // Upper half selected
	logic ok; // Guard passes
	logic acc; // Access phase taking effect
	logic wr; // Accepted write
	logic rd; // Accepted read

	assign wa = {bus.paddr[tmr_pkg::AW-1:2], 2'b00};
	assign upper = bus.paddr[tmr_pkg::HALF_BIT];
	assign ok = access_ok(st, wa, bus.pprot);
	assign acc = bus.psel & bus.penable & ok;
	assign wr = acc & bus.pwrite;
	assign rd = acc & ~bus.pwrite;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic [31:0] word;
		word = word_value(st, wa);
		next_st = st;

		// Setup phase: prepare read data and refusal for access phase
		if (bus.psel && !bus.penable) begin
			next_st.rdata = upper ? word[31:16] : word[15:0];
			next_st.err = ~ok;
			for (int t = 0; t < tmr_pkg::NUM_TIMERS; t++) begin
				if (wa == tbase(t) + tmr_pkg::OFF_LIVE && upper) begin
					next_st.rdata = st.tm[t].snap;
				end
				// Freeze upper half with the low half
				// Counting clock is clk, so never undefined
				if (wa == tbase(t) + tmr_pkg::OFF_LIVE && !upper
					&& !bus.pwrite && ok) begin
					next_st.tm[t].snap = st.tm[t].count[31:16];
				end
			end
			// Refused reads return zero, no register leaks
			if (!ok) begin
				next_st.rdata = '0;
			end
		end

		for (int t = 0; t < tmr_pkg::NUM_TIMERS; t++) begin
			// Bus effects first, so that a counter event below wins
			// End-of-interrupt reads clear
			if (rd && (wa == tbase(t) + tmr_pkg::OFF_EOI
				|| wa == tmr_pkg::OFF_ALL_EOI)) begin
				next_st.tm[t].raw = 1'b0;
			end
			if (wr && wa == tbase(t) + tmr_pkg::OFF_LOAD) begin
				if (upper) begin
					next_st.tm[t].load = {bus.pwdata, st.tm[t].sh_load};
				end else begin
					next_st.tm[t].sh_load = bus.pwdata;
				end
			end
			if (tmr_pkg::EXT_MODE && wr
				&& wa == tslot(tmr_pkg::OFF_LOAD2, t)) begin
				if (upper) begin
					next_st.tm[t].load2 = {bus.pwdata, st.tm[t].sh_load2};
				end else begin
					next_st.tm[t].sh_load2 = bus.pwdata;
				end
			end
			if (wr && !upper && wa == tbase(t) + tmr_pkg::OFF_CTRL) begin
				next_st.tm[t].ctrl = bus.pwdata[tmr_pkg::CTRL_W-1:0];
				if (!tmr_pkg::EXT_MODE) begin
					next_st.tm[t].ctrl[tmr_pkg::CTRL_PWM] = 1'b0;
				end
			end
			if (tmr_pkg::GUARD_PRESENT && wr && !upper
				&& wa == tslot(tmr_pkg::OFF_GUARD, t)) begin
				next_st.tm[t].guard = bus.pwdata[tmr_pkg::GUARD_W-1:0];
			end

			// Counter
			next_st.tm[t].en_d = st.tm[t].ctrl[tmr_pkg::CTRL_EN];
			if (!st.tm[t].ctrl[tmr_pkg::CTRL_EN]) begin
				// Disabled: hold, output low
				next_st.tm[t].tog = 1'b0;
			end else if (!st.tm[t].en_d) begin
				next_st.tm[t].count = st.tm[t].load;
				next_st.tm[t].tog = 1'b0;
			end else if (st.tm[t].ctrl[tmr_pkg::CTRL_FULL]
				&& st.tm[t].ctrl[tmr_pkg::CTRL_PWM]) begin
				next_st.tm[t].tog = (st.tm[t].load2 != 32'h0);
			end else if (st.tm[t].count == 32'h0) begin
				// Expiry: flag, flip output, reload
				next_st.tm[t].raw = 1'b1;
				next_st.tm[t].tog = ~st.tm[t].tog;
				if (!st.tm[t].ctrl[tmr_pkg::CTRL_MODE]) begin
					next_st.tm[t].count = tmr_pkg::FREE_RELOAD;
				end else if (!st.tm[t].tog
					&& st.tm[t].ctrl[tmr_pkg::CTRL_PWM]) begin
					next_st.tm[t].count = st.tm[t].load2;
				end else begin
					next_st.tm[t].count = st.tm[t].load;
				end
			end else begin
				next_st.tm[t].count = st.tm[t].count - 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			for (int t = 0; t < tmr_pkg::NUM_TIMERS; t++) begin
				st.tm[t].guard <= tmr_pkg::GUARD_RESET;
			end
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus.pready = bus.psel & bus.penable;
	assign bus.prdata = st.rdata;
	// Refusal visible only during the access phase
	assign bus.pslverr = bus.psel & bus.penable & st.err;

	// Per-timer outputs
	generate
		for (genvar g = 0; g < tmr_pkg::NUM_TIMERS; g++) begin : g_out
			assign timer_toggle[g] = st.tm[g].tog;
			assign timer_irq[g] = masked(st.tm[g]);
		end
	endgenerate

endmodule : tmr_device

// [rtl/tmr_host.sv]
// Bus master end: turns 32-bit register requests into two 16-bit
// transfers, lower half first. Assumes the slave answers every access.
`timescale 1ns/1ps

module tmr_host (
	input wire logic clk,
	input wire logic srst,
	tmr_bus_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [tmr_pkg::AW-1:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic [2:0] cmd_prot,
	output logic rsp_valid,
	output logic [31:0] rsp_rdata,
	output logic rsp_err
);

	////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [1:0] {IDLE, SETUP, ACCESS} phase_t;

	typedef struct packed {
		phase_t phase; // Transfer phase
		logic upper; // Working on upper half
		logic [tmr_pkg::AW-1:0] addr; // Word address
		logic [31:0] wdata; // Write word
		logic [31:0] rdata; // Collected read word
		logic write; // Direction
		logic [2:0] prot; // Protection
		logic err; // Any half refused
		logic rsp; // Response pulse
	} host_state_t;

	host_state_t st; // Registered state
	host_state_t next_st; // Next state

	////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_st = st;
		next_st.rsp = 1'b0;
		case (st.phase)
			IDLE: begin
				// Accept a request
				if (cmd_valid) begin
					next_st.phase = SETUP;
					next_st.upper = 1'b0;
					next_st.addr = {cmd_addr[tmr_pkg::AW-1:2], 2'b00};
					next_st.wdata = cmd_wdata;
					next_st.write = cmd_write;
					next_st.prot = cmd_prot;
					next_st.err = 1'b0;
				end
			end
			SETUP: begin
				next_st.phase = ACCESS;
			end
			ACCESS: begin
				// Wait for the slave
				if (bus.pready) begin
					next_st.err = st.err | bus.pslverr;
					if (!st.upper) begin
						next_st.rdata[15:0] = bus.prdata;
						next_st.upper = 1'b1;
						next_st.phase = SETUP;
					end else begin
						next_st.rdata[31:16] = bus.prdata;
						next_st.rsp = 1'b1;
						next_st.phase = IDLE;
					end
				end
			end
			default: begin
				next_st.phase = IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, all from state
	assign cmd_ready = (st.phase == IDLE);
	assign bus.psel = (st.phase != IDLE);
	assign bus.penable = (st.phase == ACCESS);
	assign bus.pwrite = st.write;
	assign bus.pprot = st.prot;
	assign bus.paddr = st.upper ? st.addr + tmr_pkg::HALF_STEP : st.addr;
	assign bus.pwdata = st.upper ? st.wdata[31:16] : st.wdata[15:0];
	assign rsp_valid = st.rsp;
	assign rsp_rdata = st.rdata;
	assign rsp_err = st.err;

endmodule : tmr_host

// [rtl/tmr_pkg.sv]
// Constants, options and register map of the two-channel down-counting
// timer and of the bus master that programs it.
// Assumes one clock for bus and counting, and a 16-bit register bus.
// Functional notes
// - Raw status shows unmasked interrupt per timer
// - Raw status upper bits zero, resets zero
// - Read-only release register equals build parameter
// - Rising toggle loads high-phase reload value
// - High-phase reload exists with extended mode only
// - Set guard bits demand matching bus protection
// - Guard writable unless hardcoded, resets to parameter
// - Guard register present only under listed options
// - Timers disabled at reset, software enables
// - Enabling loads the first reload value
// - All registers little-endian
// - Wide live count read coherently via snapshot
// - Without coherency, reader reads low-high-low
// - Software writes and reads low before high
// - Low halves shadowed, top half commits reload
// - Live count undefined with asynchronous counting clock
// - Fixed duty: disable, program, set bits, user mode
// - Enable last; output held high or low
// - Counter stopped while fixed duty active
// - Control bit3 PWM, bit4 fixed duty
// - Mode bit: 1 user-defined, 0 free-running

package tmr_pkg;

	////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_TIMERS = 2; // Configured timers
	localparam int TW = 32; // Timer width
	localparam int DW = 16; // Register bus data width
	localparam int AW = 8; // Register bus address width
	localparam int CTRL_W = 5; // Implemented control bits
	localparam int GUARD_W = 3; // Access guard width

	////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [AW-1:0] OFF_LOAD = 8'h00;
	localparam logic [AW-1:0] OFF_LIVE = 8'h04;
	localparam logic [AW-1:0] OFF_CTRL = 8'h08;
	localparam logic [AW-1:0] OFF_EOI = 8'h0c;
	localparam logic [AW-1:0] OFF_ISTAT = 8'h10;
	localparam logic [AW-1:0] TIMER_STRIDE = 8'h14;
	localparam logic [AW-1:0] OFF_ALL_ISTAT = 8'ha0;
	localparam logic [AW-1:0] OFF_ALL_EOI = 8'ha4;
	localparam logic [AW-1:0] OFF_RAW = 8'ha8;
	localparam logic [AW-1:0] OFF_REL = 8'hac;
	localparam logic [AW-1:0] OFF_LOAD2 = 8'hb0;
	localparam logic [AW-1:0] OFF_GUARD = 8'hd0;
	localparam logic [AW-1:0] REG_STRIDE = 8'h04;
	localparam logic [AW-1:0] HALF_STEP = 8'h02; // Upper half offset
	localparam int HALF_BIT = 1; // Address bit picking the half

	////////////////////////////////////////////////////////////////////
	// Control field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_MASK = 2;
	localparam int CTRL_PWM = 3;
	localparam int CTRL_FULL = 4;

	////////////////////////////////////////////////////////////////////
	// Build options
	localparam bit EXT_MODE = 1'b1; // Extended mode option
	localparam bit GUARD_HARDCODED = 1'b0;
	localparam bit ERR_RESP_OPTION = 1'b1;
	localparam int SLAVE_IF_TYPE = 2;
	localparam bit GUARD_PRESENT = (SLAVE_IF_TYPE > 1) && ERR_RESP_OPTION
		&& !GUARD_HARDCODED;
	localparam logic [GUARD_W-1:0] GUARD_RESET = 3'h0;
	// Release value, arbitrary
	localparam logic [31:0] RELEASE_PARAM = 32'h0001_0000;
	localparam logic [TW-1:0] FREE_RELOAD = 32'hffff_ffff;

endpackage : tmr_pkg

// [testbench/apb_timer_status_pwm_programming_tb_top.sv]
// Self-checking bench: bus master and timer block joined by the bus.
// Assumes package and interface compile first; one 100 MHz clock.
`timescale 1ns/1ps

module apb_timer_status_pwm_programming_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cmd_valid = 1'b0; // Command port, driven 1 ns after edges
	logic cmd_write = 1'b0;
	logic [7:0] cmd_addr = 8'h00;
	logic [31:0] cmd_wdata = 32'h0;
	logic [2:0] prot = 3'h0; // Protection used by every command
	logic cmd_ready, rsp_valid, rsp_err;
	logic [31:0] rsp_rdata, rdat, rdat2;
	logic [1:0] timer_toggle, timer_irq;
	logic rerr; // Refusal flag of last command
	int error_cnt = 0;
	int total_checks = 0;
	integer seed = 32'h2cb9d664;
	int model_load[2]; // Model of first reload values
	int model_high[2]; // Model of high-phase reload values
	int phase_q[$]; // Expected toggle phase lengths
	int n, h;

	always #5 clk = ~clk;

	tmr_bus_if bus (.clk(clk));
	tmr_device tmr_device_inst (.clk(clk), .srst(srst), .bus(bus),
		.timer_toggle(timer_toggle), .timer_irq(timer_irq));
	tmr_host tmr_host_inst (.clk(clk), .srst(srst), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_prot(prot), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
	tmr_bus_asserts tmr_bus_asserts_inst (.clk(clk), .srst(srst),
		.psel(bus.psel), .penable(bus.penable), .pwrite(bus.pwrite),
		.paddr(bus.paddr), .pwdata(bus.pwdata), .pprot(bus.pprot),
		.prdata(bus.prdata), .pready(bus.pready), .pslverr(bus.pslverr));

	////////////////////////////////////////////////////////////////////
	// Verdict, comparison, addresses and bus commands
	task end_of_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Per-timer block and per-timer system register addresses
	function automatic logic [7:0] blk(input int t, input logic [7:0] o);
		return o + 8'(t) * tmr_pkg::TIMER_STRIDE;
	endfunction : blk
	function automatic logic [7:0] per(input int t, input logic [7:0] o);
		return o + 8'(t) * tmr_pkg::REG_STRIDE;
	endfunction : per

	// One command; accepted at the first edge since host is idle
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		k = 0;
		// Bounded wait; a missing response counts as a mismatch
		while (rsp_valid !== 1'b1 && k < 20) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("response", 32'(k < 20), 32'h1);
		rdat = rsp_rdata;
		rerr = rsp_err;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	// Live count just after enable sits a few cycles below reload
	task live_near(input int t);
		// Coherent block, so one low-high read is enough
		rd(blk(t, tmr_pkg::OFF_LIVE));
		chk("live", 32'(rdat <= model_load[t] && rdat + 12 > model_load[t]),
			32'h1);
	endtask : live_near

	// Cycles until timer 1 output leaves level v
	task run_len(input logic v, output int len);
		len = 0;
		while (timer_toggle[1] === v && len < 200) begin
			@(posedge clk);
			#1;
			len++;
		end
	endtask : run_len

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1;
		srst = 1'b0;
		rd(tmr_pkg::OFF_RAW);
		chk("raw reset", rdat, 32'h0);
		rd(tmr_pkg::OFF_REL);
		chk("release", rdat, tmr_pkg::RELEASE_PARAM);
		for (int t = 0; t < 2; t++) begin
			rd(per(t, tmr_pkg::OFF_GUARD));
			chk("guard reset", rdat, 32'(tmr_pkg::GUARD_RESET));
			rd(blk(t, tmr_pkg::OFF_CTRL));
			chk("control reset", rdat, 32'h0);
			rd(per(t, tmr_pkg::OFF_LOAD2));
			chk("high reload reset", rdat, 32'h0);
			// Full-width random first reload exercises both halves
			model_load[t] = $random(seed);
			model_high[t] = 3 + ($random(seed) & 7);
			wr(blk(t, tmr_pkg::OFF_LOAD), model_load[t]);
			rd(blk(t, tmr_pkg::OFF_LOAD));
			chk("reload", rdat, model_load[t]);
			wr(per(t, tmr_pkg::OFF_LOAD2), model_high[t]);
			rd(per(t, tmr_pkg::OFF_LOAD2));
			chk("high reload", rdat, model_high[t]);
			n = $random(seed) & 7;
			wr(per(t, tmr_pkg::OFF_GUARD), n);
			rd(per(t, tmr_pkg::OFF_GUARD));
			chk("guard", rdat, n);
			wr(per(t, tmr_pkg::OFF_GUARD), 32'h0);
		end
		// Guard set: mismatching protection refused without effect
		wr(tmr_pkg::OFF_GUARD, 32'h5);
		prot = 3'h2;
		wr(tmr_pkg::OFF_LOAD, 32'h77);
		chk("refused write", 32'(rerr), 32'h1);
		rd(tmr_pkg::OFF_LOAD);
		chk("refused data", rdat, 32'h0);
		prot = 3'h5;
		rd(tmr_pkg::OFF_LOAD);
		chk("granted data", rdat, model_load[0]);
		chk("granted flag", 32'(rerr), 32'h0);
		prot = 3'h0;
		wr(tmr_pkg::OFF_GUARD, 32'h0);
		// Timer 0: masked expiry, sticky raw bit, end of interrupt
		model_load[0] = 40 + ($random(seed) & 15);
		wr(tmr_pkg::OFF_LOAD, model_load[0]);
		wr(tmr_pkg::OFF_CTRL, 32'h7);
		live_near(0);
		repeat (100) @(posedge clk);
		rd(tmr_pkg::OFF_RAW);
		chk("raw set", rdat, 32'h1);
		chk("masked line", 32'(timer_irq[0]), 32'h0);
		wr(tmr_pkg::OFF_CTRL, 32'h2);
		chk("sticky line", 32'(timer_irq[0]), 32'h1);
		chk("toggle off", 32'(timer_toggle[0]), 32'h0);
		rd(tmr_pkg::OFF_EOI);
		chk("end of irq", rdat, 32'h0);
		rd(tmr_pkg::OFF_RAW);
		chk("raw cleared", rdat, 32'h0);
		wr(tmr_pkg::OFF_CTRL, 32'h3);
		live_near(0);
		wr(tmr_pkg::OFF_CTRL, 32'h0);
		// Free-running: expiry reloads all ones, not the first reload
		wr(tmr_pkg::OFF_LOAD, 32'h14);
		wr(tmr_pkg::OFF_CTRL, 32'h5);
		repeat (40) @(posedge clk);
		rd(tmr_pkg::OFF_LIVE);
		chk("free reload", 32'(rdat > tmr_pkg::FREE_RELOAD - 32'h3c),
			32'h1);
		wr(tmr_pkg::OFF_CTRL, 32'h0);
		// Timer 1 PWM: high phase from second reload, low from first
		model_load[1] = 8 + ($random(seed) & 7);
		wr(blk(1, tmr_pkg::OFF_LOAD), model_load[1]);
		wr(blk(1, tmr_pkg::OFF_CTRL), 32'h0b);
		phase_q.push_back(model_high[1] + 1);
		phase_q.push_back(model_load[1] + 1);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, h);
		chk("high phase", h, phase_q.pop_front());
		run_len(1'b0, n);
		chk("low phase", n, phase_q.pop_front());
		chk("irq line", 32'(timer_irq[1]), 32'h1);
		// Fixed duty flow: stop, program, select, enable last
		for (int k = 0; k < 2; k++) begin
			wr(blk(1, tmr_pkg::OFF_CTRL), 32'h0);
			wr(blk(1, tmr_pkg::OFF_LOAD), model_load[1]);
			wr(per(1, tmr_pkg::OFF_LOAD2), k ? model_high[1] : 0);
			wr(blk(1, tmr_pkg::OFF_CTRL), 32'h1a);
			wr(blk(1, tmr_pkg::OFF_CTRL), 32'h1b);
			repeat (30) @(posedge clk);
			#1;
			chk("fixed level", 32'(timer_toggle[1]), k);
			rd(blk(1, tmr_pkg::OFF_LIVE));
			rdat2 = rdat;
			rd(blk(1, tmr_pkg::OFF_LIVE));
			chk("frozen count", rdat, rdat2);
		end
		wr(blk(1, tmr_pkg::OFF_CTRL), 32'h0b);
		run_len(timer_toggle[1], n);
		chk("toggling resumes", 32'(n < 40), 32'h1);
		wr(blk(1, tmr_pkg::OFF_CTRL), 32'h0);
		rd(tmr_pkg::OFF_ALL_EOI);
		chk("all end of irq", rdat, 32'h0);
		rd(tmr_pkg::OFF_RAW);
		chk("raw all cleared", rdat, 32'h0);
		end_of_test();
	end

	// Watchdog well beyond the expected run of under 2000 cycles
	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule : apb_timer_status_pwm_programming_tb_top

// [testbench/tmr_bus_asserts.sv]
// Checker for the register bus between the timer block and its master.
// Assumes instantiation beside the bus interface, sharing clk and srst.
`timescale 1ns/1ps

module tmr_bus_asserts (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tmr_pkg::AW-1:0] paddr,
	input wire logic [tmr_pkg::DW-1:0] pwdata,
	input wire logic [2:0] pprot,
	input wire logic [tmr_pkg::DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Read in access phase, where returned data counts
	wire logic rd_acc = psel && penable && !pwrite;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////
	// Master side: setup held into access, halves low then high
	property p_setup_hold;
		psel && !penable |=> psel && penable && $stable(paddr)
			&& $stable(pwrite) && $stable(pwdata) && $stable(pprot);
	endproperty
	a_setup_hold: assert property (p_setup_hold)
		else $error("setup values moved before access");
	property p_low_then_high;
		psel && penable && !paddr[tmr_pkg::HALF_BIT] |=> psel && !penable
			&& pwrite == $past(pwrite)
			&& paddr == $past(paddr) + tmr_pkg::HALF_STEP;
	endproperty
	a_low_then_high: assert property (p_low_then_high)
		else $error("upper half did not follow lower half");
	property p_high_ends;
		psel && penable && paddr[tmr_pkg::HALF_BIT] |=> !psel;
	endproperty
	a_high_ends: assert property (p_high_ends)
		else $error("select held after upper half");

	////////////////////////////////////////////////////////////////////
	// Device side: zero wait, fixed read values, refusal placement
	property p_zero_wait;
		pready == (psel && penable);
	endproperty
	a_zero_wait: assert property (p_zero_wait)
		else $error("ready not in access cycle");
	// Upper half all zero, lower half only timer bits
	property p_raw_reserved;
		rd_acc && (paddr & 8'hfc) == tmr_pkg::OFF_RAW |->
			(paddr[1] ? prdata : prdata >> tmr_pkg::NUM_TIMERS) == '0;
	endproperty
	a_raw_reserved: assert property (p_raw_reserved)
		else $error("raw status reserved bits set");
	property p_release;
		rd_acc && (paddr & 8'hfc) == tmr_pkg::OFF_REL |-> prdata ==
			(paddr[1] ? tmr_pkg::RELEASE_PARAM[31:16]
			: tmr_pkg::RELEASE_PARAM[15:0]);
	endproperty
	a_release: assert property (p_release)
		else $error("release value wrong");
	property p_guard_reserved;
		rd_acc && (paddr & 8'hf8) == tmr_pkg::OFF_GUARD |->
			(paddr[1] ? prdata : prdata >> tmr_pkg::GUARD_W) == '0;
	endproperty
	a_guard_reserved: assert property (p_guard_reserved)
		else $error("guard reserved bits set");
	property p_eoi_zero;
		rd_acc && (paddr == tmr_pkg::OFF_EOI || paddr == tmr_pkg::OFF_ALL_EOI
			|| paddr == tmr_pkg::OFF_EOI + tmr_pkg::TIMER_STRIDE)
			|-> prdata == '0;
	endproperty
	a_eoi_zero: assert property (p_eoi_zero)
		else $error("end of interrupt read not zero");
	// Guard itself, combined and raw status and release are never refused
	property p_err_place;
		pslverr |-> psel && penable && (paddr < tmr_pkg::OFF_ALL_ISTAT
			|| (paddr & 8'hf8) == tmr_pkg::OFF_LOAD2);
	endproperty
	a_err_place: assert property (p_err_place)
		else $error("refusal outside protected place");
endmodule : tmr_bus_asserts
